// ===== verilog/phasor_pkg.sv
// Shared constants, lookup tables and carrier types for the phasor downconverter
package phasor_pkg;
  localparam int SMP_W      = 14;
  localparam int NCH        = 6;
  localparam int COEF_W     = 16;
  localparam int ACC_W      = 40;
  localparam int PROD_SHIFT = 16;
  localparam int CX_W       = 34;
  localparam int ACC_DROP   = 6;
  localparam int MAG_W      = 24;
  localparam int ANG_W      = 16;
  localparam int STAMP_W    = 16;
  localparam int CORDIC_N   = 12;
  localparam int FIFO_DEPTH = 16;
  localparam int FS_HZ      = 4800;
  localparam int MEAS_HZ    = 50;
  localparam int FREQ_LSB   = MEAS_HZ * 1000;
  localparam int TW_SHIFT   = 10;
  localparam longint TW_MUL = (64'h1 << (32 + TW_SHIFT)) / (FS_HZ * 1000);
  localparam logic [16:0] NOM50_MHZ = 17'hc350;
  localparam logic [16:0] NOM60_MHZ = 17'hea60;
  localparam logic signed [17:0] DEV2_MHZ  = 18'sh007d0;
  localparam logic signed [17:0] DEV5_MHZ  = 18'sh01388;
  localparam logic signed [17:0] DEV10_MHZ = 18'sh02710;
  localparam logic [MAG_W-1:0] FAULT_LIM   = 24'h000400;
  localparam logic [ANG_W-1:0] HALF_TURN   = 16'h8000;
  localparam logic [2:0] LAST_CH = 3'h5;
  localparam logic signed [11:0] SIN_LUT [32] = '{
    12'sh000, 12'sh18f, 12'sh30f, 12'sh471, 12'sh5a7, 12'sh6a6, 12'sh763, 12'sh7d8,
    12'sh7ff, 12'sh7d8, 12'sh763, 12'sh6a6, 12'sh5a7, 12'sh471, 12'sh30f, 12'sh18f,
    12'sh000, -12'sh18f, -12'sh30f, -12'sh471, -12'sh5a7, -12'sh6a6, -12'sh763, -12'sh7d8,
    -12'sh7ff, -12'sh7d8, -12'sh763, -12'sh6a6, -12'sh5a7, -12'sh471, -12'sh30f, -12'sh18f};
  localparam logic [ANG_W-1:0] ATAN_LUT [CORDIC_N] = '{
    16'h2000, 16'h12e4, 16'h09fb, 16'h0511, 16'h028b, 16'h0146,
    16'h00a3, 16'h0051, 16'h0029, 16'h0014, 16'h000a, 16'h0005};
  typedef struct packed {
    logic                    valid;
    logic [2:0]              ch;
    logic signed [SMP_W-1:0] data;
  } sample_t;
  typedef struct packed {
    logic [STAMP_W-1:0] stamp;
    logic [2:0]         ch;
    logic [MAG_W-1:0]   mag;
    logic [ANG_W-1:0]   ang;
  } phasor_t;
  typedef enum logic [1:0] {CV_IDLE, CV_LOAD, CV_ROT, CV_PUSH} conv_st_t;
endpackage

// ===== verilog/adaptive_phasor_downconverter.sv
// Phasor downconverter: NCO mixer, windowed accumulator, CORDIC, adaptive tuning, FIFO
`timescale 1ns/1ps
// How it works
// R1: Each sample is multiplied by a complex sinusoid at the current centre frequency.
// R2: The baseband product is low-pass filtered and then turned into magnitude and phase.
// R3: The filter is a window estimator, each sample weighted by its window value and summed.
// R4: With tuning on, the centre follows the positive-sequence voltage frequency from dphi/dt.
// R5: The tuned offset is clamped to plus or minus 2, 5 or 10 Hz of nominal.
// R6: Tuning drops out when the magnitude disagrees with the broadband rms beyond a limit.
// R7: Samples come from one multiplexed 14-bit converter held to UTC within one microsecond.
// R8: Each estimate belongs to a prescribed reporting instant, not its computation time.
// R9: A sampling offset from the reporting instant is compensated in the mixer phase.
// R10: The window should reject twice the centre frequency by 40 dB, better 60 dB.
// R11: With tuning off the centre frequency is the nominal system frequency.
module phasor_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  input  wire logic         mclk,
  input  wire logic         rst_b,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0]  mem_r [DEPTH];
  logic [AW:0]   wr_r, wr_nxt, rd_r, rd_nxt;
  logic          push, pop;
  // Pointer arithmetic with wrap bit for honest full and empty
  always_comb begin
    in_ready  = (wr_r - rd_r) != (AW+1)'(DEPTH);
    out_valid = wr_r != rd_r;
    out_data  = mem_r[rd_r[AW-1:0]];
    push      = in_valid && in_ready;
    pop       = out_valid && out_ready;
    wr_nxt    = push ? wr_r + 1'b1 : wr_r;
    rd_nxt    = pop ? rd_r + 1'b1 : rd_r;
  end
  // Storage and pointers
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wr_r <= '0;
      rd_r <= '0;
    end else begin
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
    end
  end
  always_ff @(posedge mclk) begin
    if (push) begin
      mem_r[wr_r[AW-1:0]] <= in_data;
    end
  end
endmodule

module adaptive_phasor_downconverter (
  // Clock and reset
  input  wire logic                 mclk,
  input  wire logic                 rst_b,
  // Converter sample stream
  input  wire logic                 smp_valid,
  input  wire logic [2:0]           smp_ch,
  input  wire logic signed [13:0]   smp_data,
  // Window weight for the current frame
  input  wire logic signed [15:0]   win_coef,
  output logic [15:0]               coef_idx,
  // Record timing
  input  wire logic                 rec_start,
  input  wire logic [15:0]          rec_stamp,
  input  wire logic [15:0]          win_frames,
  input  wire logic signed [7:0]    smp_offset,
  // Tuning control
  input  wire logic                 adapt_en,
  input  wire logic                 nom_60hz,
  input  wire logic [1:0]           dev_sel,
  input  wire logic                 psv_valid,
  input  wire logic [15:0]          positive_sequence_voltage,
  input  wire logic [23:0]          rms_mag,
  // Status
  output logic                      adapt_active,
  output logic                      tune_fault,
  output logic [16:0]               centre_mhz,
  output logic                      rec_busy,
  // Phasor output stream
  output logic                      ph_valid,
  input  wire logic                 ph_ready,
  output phasor_pkg::phasor_t       ph_data
);
  localparam int ACC_W = phasor_pkg::ACC_W;
  phasor_pkg::sample_t  s1_r, s2_r;
  logic [15:0]          prev_ph_r, prev_ph_nxt;
  logic                 prev_ok_r, prev_ok_nxt, fault_r, fault_nxt, adapt_r, adapt_nxt;
  logic signed [17:0]   dev_r, dev_nxt, lim;
  logic signed [31:0]   dev_raw;
  logic [16:0]          nom, centre_r, centre_nxt;
  logic [31:0]          tw_r, tw_nxt, phase_r, phase_nxt, comp, mix_ph;
  logic signed [40:0]   comp_full;
  logic signed [ACC_W-1:0] acc_i_r [phasor_pkg::NCH], acc_i_nxt [phasor_pkg::NCH];
  logic signed [ACC_W-1:0] acc_q_r [phasor_pkg::NCH], acc_q_nxt [phasor_pkg::NCH];
  logic signed [25:0]   p_i, p_q;
  logic signed [41:0]   w_i, w_q;
  logic [15:0]          frames_r, frames_nxt, stamp_r, stamp_nxt;
  logic                 rec_on_r, rec_on_nxt, rec_done;
  phasor_pkg::conv_st_t st_r, st_nxt;
  logic [2:0]           cch_r, cch_nxt;
  logic [3:0]           it_r, it_nxt;
  logic signed [33:0]   x_r, x_nxt, y_r, y_nxt, ld_x, ld_y;
  logic [15:0]          z_r, z_nxt;
  logic                 push, f_ready;
  phasor_pkg::phasor_t  push_data;
  logic [23:0]          mag_diff;
  logic                 busy_r, busy_nxt;

  // R7: converter stream through two flops
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s1_r <= '0;
      s2_r <= '0;
    end else begin
      s1_r <= '{valid: smp_valid, ch: smp_ch, data: smp_data};
      s2_r <= s1_r;
    end
  end

  // Tuning: frequency estimate, clamp, fault and tuning word
  always_comb begin
    nom         = nom_60hz ? phasor_pkg::NOM60_MHZ : phasor_pkg::NOM50_MHZ;
    prev_ph_nxt = psv_valid ? positive_sequence_voltage : prev_ph_r;
    prev_ok_nxt = adapt_en && (prev_ok_r || psv_valid);
    // R4: dphi per measurement interval scaled to mHz
    dev_raw = (32'(signed'(positive_sequence_voltage - prev_ph_r)) * phasor_pkg::FREQ_LSB)
              >>> 16;
    case (dev_sel)
      2'h0:    lim = phasor_pkg::DEV2_MHZ;
      2'h1:    lim = phasor_pkg::DEV5_MHZ;
      default: lim = phasor_pkg::DEV10_MHZ;
    endcase
    dev_nxt = dev_r;
    if (psv_valid && prev_ok_r) begin
      // R5: clamp to the selected tracking limit
      if (dev_raw > 32'(lim)) dev_nxt = lim;
      else if (dev_raw < -32'(lim)) dev_nxt = -lim;
      else dev_nxt = 18'(dev_raw);
    end
    mag_diff = (push_data.mag > rms_mag) ? push_data.mag - rms_mag : rms_mag - push_data.mag;
    // R6: sticky fault until tuning is switched off; a new mismatch wins
    fault_nxt  = (fault_r && adapt_en) ||
                 (push && push_data.ch == 3'h0 && mag_diff > phasor_pkg::FAULT_LIM);
    adapt_nxt  = adapt_en && !fault_nxt;
    // R11: nominal centre whenever tuning is inactive
    centre_nxt = adapt_r ? 17'(signed'({1'b0, nom}) + dev_r) : nom;
    tw_nxt     = 32'((longint'(centre_r) * phasor_pkg::TW_MUL) >> phasor_pkg::TW_SHIFT);
  end
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      prev_ph_r <= '0;
      prev_ok_r <= 1'b0;
      dev_r     <= '0;
      fault_r   <= 1'b0;
      adapt_r   <= 1'b0;
      centre_r  <= phasor_pkg::NOM50_MHZ;
      tw_r      <= '0;
    end else begin
      prev_ph_r <= prev_ph_nxt;
      prev_ok_r <= prev_ok_nxt;
      dev_r     <= dev_nxt;
      fault_r   <= fault_nxt;
      adapt_r   <= adapt_nxt;
      centre_r  <= centre_nxt;
      tw_r      <= tw_nxt;
    end
  end

  // Mixer and windowed accumulation
  always_comb begin
    // R9: rotate the mixer by the sampling offset in 1/256 sample steps
    comp_full = (signed'({9'h0, tw_r}) * smp_offset) >>> 8;
    comp      = comp_full[31:0];
    mix_ph    = phase_r + comp;
    // R1: complex mix to baseband
    p_i = s2_r.data * phasor_pkg::SIN_LUT[5'(mix_ph[31:27] + 5'h08)];
    p_q = -(s2_r.data * phasor_pkg::SIN_LUT[mix_ph[31:27]]);
    // R3: weight by the window before accumulating
    // R10: rejection depends on the window fed in on win_coef
    w_i = p_i * win_coef;
    w_q = p_q * win_coef;
    acc_i_nxt  = acc_i_r;
    acc_q_nxt  = acc_q_r;
    phase_nxt  = phase_r;
    frames_nxt = frames_r;
    rec_on_nxt = rec_on_r;
    stamp_nxt  = stamp_r;
    rec_done   = 1'b0;
    if (s2_r.valid && s2_r.ch == phasor_pkg::LAST_CH) begin
      phase_nxt = phase_r + tw_r;
    end
    if (rec_on_r && s2_r.valid && s2_r.ch <= phasor_pkg::LAST_CH) begin
      acc_i_nxt[s2_r.ch] = acc_i_r[s2_r.ch] + ACC_W'(w_i >>> phasor_pkg::PROD_SHIFT);
      acc_q_nxt[s2_r.ch] = acc_q_r[s2_r.ch] + ACC_W'(w_q >>> phasor_pkg::PROD_SHIFT);
      if (s2_r.ch == phasor_pkg::LAST_CH) begin
        frames_nxt = frames_r + 1'b1;
        rec_done   = (frames_r + 1'b1) >= win_frames;
        rec_on_nxt = !rec_done;
      end
    end else if (!rec_on_r && rec_start && st_r == phasor_pkg::CV_IDLE) begin
      // R8: record is bound to its reporting instant stamp
      for (int k = 0; k < phasor_pkg::NCH; k++) begin
        acc_i_nxt[k] = '0;
        acc_q_nxt[k] = '0;
      end
      frames_nxt = '0;
      rec_on_nxt = 1'b1;
      stamp_nxt  = rec_stamp;
    end
  end
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      phase_r  <= '0;
      frames_r <= '0;
      rec_on_r <= 1'b0;
      stamp_r  <= '0;
      for (int k = 0; k < phasor_pkg::NCH; k++) begin
        acc_i_r[k] <= '0;
        acc_q_r[k] <= '0;
      end
    end else begin
      phase_r  <= phase_nxt;
      frames_r <= frames_nxt;
      rec_on_r <= rec_on_nxt;
      stamp_r  <= stamp_nxt;
      acc_i_r  <= acc_i_nxt;
      acc_q_r  <= acc_q_nxt;
    end
  end

  // R2: CORDIC vectoring of each channel into magnitude and angle
  always_comb begin
    st_nxt  = st_r;
    cch_nxt = cch_r;
    it_nxt  = it_r;
    x_nxt   = x_r;
    y_nxt   = y_r;
    z_nxt   = z_r;
    push    = 1'b0;
    ld_x    = 34'(acc_i_r[cch_r] >>> phasor_pkg::ACC_DROP);
    ld_y    = 34'(acc_q_r[cch_r] >>> phasor_pkg::ACC_DROP);
    push_data = '{stamp: stamp_r, ch: cch_r, mag: x_r[32:9], ang: z_r};
    case (st_r)
      phasor_pkg::CV_IDLE: begin
        cch_nxt = '0;
        if (rec_done) st_nxt = phasor_pkg::CV_LOAD;
      end
      phasor_pkg::CV_LOAD: begin
        x_nxt  = ld_x[33] ? -ld_x : ld_x;
        y_nxt  = ld_x[33] ? -ld_y : ld_y;
        z_nxt  = ld_x[33] ? phasor_pkg::HALF_TURN : '0;
        it_nxt = '0;
        st_nxt = phasor_pkg::CV_ROT;
      end
      phasor_pkg::CV_ROT: begin
        if (!y_r[33]) begin
          x_nxt = x_r + (y_r >>> it_r);
          y_nxt = y_r - (x_r >>> it_r);
          z_nxt = z_r + phasor_pkg::ATAN_LUT[it_r];
        end else begin
          x_nxt = x_r - (y_r >>> it_r);
          y_nxt = y_r + (x_r >>> it_r);
          z_nxt = z_r - phasor_pkg::ATAN_LUT[it_r];
        end
        it_nxt = it_r + 1'b1;
        if (it_r == 4'(phasor_pkg::CORDIC_N - 1)) st_nxt = phasor_pkg::CV_PUSH;
      end
      phasor_pkg::CV_PUSH: begin
        push = f_ready;
        if (f_ready) begin
          cch_nxt = cch_r + 1'b1;
          st_nxt  = (cch_r == phasor_pkg::LAST_CH) ? phasor_pkg::CV_IDLE : phasor_pkg::CV_LOAD;
        end
      end
      default: st_nxt = phasor_pkg::CV_IDLE;
    endcase
    // Busy from next values so the status pin leaves a flop
    busy_nxt = rec_on_nxt || (st_nxt != phasor_pkg::CV_IDLE);
  end
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_r  <= phasor_pkg::CV_IDLE;
      busy_r <= 1'b0;
      cch_r <= '0;
      it_r  <= '0;
      x_r   <= '0;
      y_r   <= '0;
      z_r   <= '0;
    end else begin
      st_r  <= st_nxt;
      busy_r <= busy_nxt;
      cch_r <= cch_nxt;
      it_r  <= it_nxt;
      x_r   <= x_nxt;
      y_r   <= y_nxt;
      z_r   <= z_nxt;
    end
  end

  // Output queue with back-pressure into the converter stage
  phasor_fifo #(.W($bits(phasor_pkg::phasor_t)), .DEPTH(phasor_pkg::FIFO_DEPTH)) u_fifo (
    .mclk      (mclk),
    .rst_b     (rst_b),
    .in_valid  (push),
    .in_ready  (f_ready),
    .in_data   (push_data),
    .out_valid (ph_valid),
    .out_ready (ph_ready),
    .out_data  (ph_data)
  );
  assign coef_idx     = frames_r;
  assign adapt_active = adapt_r;
  assign tune_fault   = fault_r;
  assign centre_mhz   = centre_r;
  assign rec_busy     = busy_r;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  sequence frame_end_s;
    s2_r.valid && s2_r.ch == phasor_pkg::LAST_CH;
  endsequence
  sequence tune_off_s;
    !adapt_en ##1 1'b1;
  endsequence
  sample_sync_a: assert property (smp_valid |-> ##2 s2_r.valid) // R7
    else $error("sample lost in synchroniser");
  nco_step_a: assert property (frame_end_s |=> phase_r == $past(phase_r) + $past(tw_r)) // R1
    else $error("mixer phase did not advance");
  acc_hold_a: assert property (!rec_on_r && !rec_start |=> $stable(acc_i_r[0])) // R3
    else $error("accumulator moved outside a record");
  conv_done_a: assert property (st_r == phasor_pkg::CV_LOAD |-> // R2
    ##13 st_r == phasor_pkg::CV_PUSH)
    else $error("rotation did not finish");
  rec_kick_a: assert property (rec_done |=> st_r == phasor_pkg::CV_LOAD) // R2
    else $error("conversion did not start");
  clamp_lim_a: assert property (dev_r <= phasor_pkg::DEV10_MHZ && // R5
    dev_r >= -phasor_pkg::DEV10_MHZ)
    else $error("tuning offset beyond limit");
  fault_off_a: assert property (fault_nxt |=> !adapt_r ##1 centre_r == $past(nom)) // R6
    else $error("tuning stayed on after fault");
  nominal_a: assert property (tune_off_s |=> centre_r == $past(nom)) // R11
    else $error("centre not nominal with tuning off");
  stamp_tag_a: assert property (push |-> push_data.stamp == stamp_r && !rec_on_r) // R8
    else $error("estimate not tied to its instant");
  offset_zero_a: assert property (smp_offset == 8'sh00 |-> mix_ph == phase_r) // R9
    else $error("offset rotation with zero offset");
  offset_turn_a: assert property (smp_offset == 8'sh40 |-> mix_ph - phase_r == tw_r >> 2) // R9
    else $error("quarter sample offset not rotated");
endmodule

// ===== test/conv_model.sv
// Model of the multiplexed sampling converter that feeds the downconverter
`timescale 1ns/1ps
module conv_model (
  // Clock and control
  input  wire logic          mclk,
  input  wire logic          run,
  // Sample stream
  output logic               smp_valid,
  output logic [2:0]         smp_ch,
  output logic signed [13:0] smp_data
);
  int slot = 0;
  int c    = 0;
  int n    = 0;

  initial begin
    smp_valid = 1'b0;
    smp_ch    = 3'h0;
    smp_data  = 14'sh0000;
  end

  // one 14-bit converter steps ch0..ch5, one sample every third cycle
  always @(negedge mclk) begin
    slot <= (slot == 2) ? 0 : slot + 1;
    if (run && slot == 0) begin
      smp_valid <= 1'b1;
      smp_ch    <= c[2:0];
      smp_data  <= 14'($rtoi(c * 1000.0 * $sin(6.283185307 * n / 96.0)));
      c         <= (c == 5) ? 0 : c + 1;
      n         <= (c == 5) ? n + 1 : n;
    end else begin
      smp_valid <= 1'b0;
      smp_data  <= ~smp_data; // Stale data never looks valid
    end
  end
endmodule

// ===== test/adaptive_phasor_downconverter_bench.sv
// Self-checking testbench of the adaptive phasor downconverter
`timescale 1ns/1ps
module adaptive_phasor_downconverter_bench;
  logic                smp_valid, mclk, rst_b, rec_start, adapt_en, nom_60hz, psv_valid;
  logic                adapt_active, tune_fault, rec_busy, ph_valid, ph_ready;
  logic [2:0]          smp_ch;
  logic signed [13:0]  smp_data;
  logic signed [15:0]  win_coef;
  logic signed [7:0]   smp_offset;
  logic [15:0]         coef_idx, rec_stamp, win_frames, positive_sequence_voltage;
  logic [1:0]          dev_sel;
  logic [23:0]         rms_mag;
  logic [16:0]         centre_mhz;
  phasor_pkg::phasor_t ph_data;
  phasor_pkg::phasor_t got_q[$];
  int                  failures = 0;
  int                  cmp_count = 0;

  // Rectangular window inside the record
  assign win_coef = (coef_idx < win_frames) ? 16'sh7fff : 16'sh0000;

  conv_model SRC (.mclk(mclk), .run(rst_b), .smp_valid(smp_valid), .smp_ch(smp_ch),
                  .smp_data(smp_data));

  adaptive_phasor_downconverter DUT (
    .mclk(mclk), .rst_b(rst_b), .smp_valid(smp_valid), .smp_ch(smp_ch),
    .smp_data(smp_data), .win_coef(win_coef), .coef_idx(coef_idx),
    .rec_start(rec_start), .rec_stamp(rec_stamp), .win_frames(win_frames),
    .smp_offset(smp_offset), .adapt_en(adapt_en), .nom_60hz(nom_60hz), .dev_sel(dev_sel),
    .psv_valid(psv_valid), .positive_sequence_voltage(positive_sequence_voltage),
    .rms_mag(rms_mag), .adapt_active(adapt_active), .tune_fault(tune_fault),
    .centre_mhz(centre_mhz), .rec_busy(rec_busy), .ph_valid(ph_valid),
    .ph_ready(ph_ready), .ph_data(ph_data));

  // Clock
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // Collect every phasor the sink accepts
  always @(posedge mclk) begin
    if (ph_valid === 1'b1 && ph_ready === 1'b1) begin
      got_q.push_back(ph_data);
    end
  end

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check_val(input logic [23:0] got, input logic [23:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wait_idle(input int bound);
    int i;
    i = 0;
    while (rec_busy !== 1'b0 && i < bound) begin
      @(negedge mclk);
      i++;
    end
    if (i >= bound) begin
      failures++;
      $display("ERROR at %0t: record never finished", $time);
      print_verdict();
    end
  endtask

  task automatic start_rec(input logic [15:0] stamp, input logic [15:0] frames);
    @(negedge mclk);
    rec_stamp  = stamp;
    win_frames = frames;
    rec_start  = 1'b1;
    @(negedge mclk);
    rec_start  = 1'b0;
  endtask

  task automatic psv(input logic [15:0] phase);
    @(negedge mclk);
    positive_sequence_voltage = phase;
    psv_valid = 1'b1;
    @(negedge mclk);
    psv_valid = 1'b0;
  endtask

  // Six phasors ch0..ch5 carrying one stamp, from queue position base
  task automatic check_rec(input int base, input logic [15:0] stamp);
    for (int k = 0; k < 6; k++) begin
      check_val(24'(got_q[base+k].ch), 24'(k), "channel");
      check_val(24'(got_q[base+k].stamp), 24'(stamp), "stamp");
    end
  endtask

  task automatic test_nominal();
    check_val(24'(centre_mhz), 24'(phasor_pkg::NOM50_MHZ), "reset centre");
    check_val(24'(ph_valid), 24'h0, "reset valid");
    nom_60hz = 1'b1;
    repeat (3) @(negedge mclk);
    check_val(24'(centre_mhz), 24'(phasor_pkg::NOM60_MHZ), "60 Hz centre");
    nom_60hz = 1'b0;
    repeat (3) @(negedge mclk);
    $display("Test nominal done");
  endtask

  task automatic test_record();
    got_q.delete();
    start_rec(16'h1234, 16'd96);
    check_val(24'(rec_busy), 24'h1, "busy");
    start_rec(16'h5678, 16'd96);
    wait_idle(8000);
    repeat (4) @(negedge mclk);
    check_val(24'(got_q.size()), 24'd6, "phasor count");
    if (got_q.size() == 6) begin
      check_rec(0, 16'h1234);
      check_val(got_q[0].mag, 24'h0, "silent channel");
      check_val(24'(got_q[5].mag > got_q[1].mag), 24'h1, "magnitude order");
    end
    $display("Test record done");
  endtask

  task automatic test_fifo();
    got_q.delete();
    ph_ready = 1'b0;
    start_rec(16'h0a01, 16'd1);
    wait_idle(2000);
    start_rec(16'h0a02, 16'd1);
    wait_idle(2000);
    start_rec(16'h0a03, 16'd1);
    repeat (600) @(negedge mclk);
    check_val(24'(rec_busy), 24'h1, "stalled while full");
    check_val(24'(ph_valid), 24'h1, "full valid");
    ph_ready = 1'b1;
    wait_idle(2000);
    repeat (4) @(negedge mclk);
    check_val(24'(got_q.size()), 24'd18, "drained count");
    if (got_q.size() == 18) begin
      for (int r = 0; r < 3; r++) begin
        check_rec(r * 6, 16'h0a01 + 16'(r));
      end
    end
    $display("Test fifo done");
  endtask

  task automatic test_tune();
    logic [16:0] exp_c [4] = '{17'hcb20, 17'hd6d8, 17'hea60, 17'hea60};
    for (int d = 0; d < 4; d++) begin
      adapt_en = 1'b0;
      repeat (3) @(negedge mclk);
      dev_sel  = d[1:0];
      adapt_en = 1'b1;
      psv(16'h0000);
      psv(16'h4000);
      repeat (4) @(negedge mclk);
      check_val(24'(centre_mhz), 24'(exp_c[d]), "clamped centre");
      check_val(24'(adapt_active), 24'h1, "tuning on");
    end
    dev_sel = 2'h1;
    psv(16'h0000);
    repeat (4) @(negedge mclk);
    check_val(24'(centre_mhz), 24'(17'hafc8), "clamped low");
    adapt_en = 1'b0;
    repeat (3) @(negedge mclk);
    check_val(24'(centre_mhz), 24'(phasor_pkg::NOM50_MHZ), "tuning off");
    $display("Test tune done");
  endtask

  task automatic test_fault();
    rms_mag  = 24'hffffff;
    dev_sel  = 2'h2;
    smp_offset = 8'sh40;
    adapt_en = 1'b1;
    psv(16'h0000);
    psv(16'h4000);
    start_rec(16'h0abc, 16'd1);
    wait_idle(2000);
    repeat (3) @(negedge mclk);
    check_val(24'(tune_fault), 24'h1, "fault set");
    check_val(24'(adapt_active), 24'h0, "tuning dropped");
    check_val(24'(centre_mhz), 24'(phasor_pkg::NOM50_MHZ), "fault centre");
    adapt_en = 1'b0;
    rms_mag  = 24'h000000;
    smp_offset = 8'sh00;
    repeat (3) @(negedge mclk);
    check_val(24'(tune_fault), 24'h0, "fault cleared");
    $display("Test fault done");
  endtask

  // Main sequence
  initial begin
    rst_b = 1'b0;
    rec_start = 1'b0;
    rec_stamp = 16'h0000;
    win_frames = 16'd1;
    adapt_en = 1'b0;
    nom_60hz = 1'b0;
    dev_sel = 2'h0;
    psv_valid = 1'b0;
    positive_sequence_voltage = 16'h0000;
    rms_mag = 24'h000000;
    smp_offset = 8'sh00;
    ph_ready = 1'b1;
    repeat (5) @(negedge mclk);
    rst_b = 1'b1;
    test_nominal();
    test_record();
    test_fifo();
    test_tune();
    test_fault();
    print_verdict();
  end
endmodule
